// >>> bench/sqf_checker.sv
`timescale 1ns/100ps
// ==========================================================================
// port checks on the serial read path
module sqf_checker #(
  parameter int AW = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial port and sensor strobe
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic sample_strobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // driver enable follows select and the serial clock phase
  a_oe_idle_low: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_oe_rise_sel: assert property ($rose(spi_miso_oe) |-> !spi_cs_n && !$past(spi_cs_n, 2))
    else $error("miso enable rose without select");
  a_oe_rise_low: assert property ($rose(spi_miso_oe) |-> !spi_clk && !$past(spi_clk))
    else $error("miso enable rose outside clock low phase");
  a_oe_keep_sel: assert property (spi_miso_oe && !spi_cs_n |=> spi_miso_oe)
    else $error("miso enable dropped inside operation");
  a_oe_fall_cause: assert property ($fell(spi_miso_oe) |-> $past(spi_cs_n))
    else $error("miso enable fell while selected");
  // data may only move after a falling clock edge
  a_miso_hold_high: assert property ((!spi_cs_n && spi_clk) [*4] |-> $stable(spi_miso))
    else $error("miso moved in clock high phase");
  a_miso_idle_quiet: assert property (spi_cs_n [*6] |-> $stable(spi_miso))
    else $error("miso moved while deselected");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !spi_miso && !spi_miso_oe)
    else $error("serial outputs active in reset");

  // main scenarios
  c_read_start: cover property ($rose(spi_miso_oe));
  c_read_end: cover property ($fell(spi_miso_oe));
  c_sample: cover property (sample_strobe);
endmodule : sqf_checker

bind sqf_top sqf_checker #(.AW(AW)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .sample_strobe(sample_strobe));

// >>> bench/sqf_host.sv
`timescale 1ns/100ps
// ==========================================================================
// host model: serial master, mode 0, clock stands still between operations
module sqf_host (
  // clock
  input  wire logic       clk_sys,
  // serial lines
  output logic            spi_clk,
  output logic            spi_cs_n,
  output logic            spi_mosi,
  input  wire logic       spi_miso,
  // received byte, strobed for the bench watcher
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  // idle lines at time zero
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  // half period of four system clocks keeps the design's sampling margin
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : half

  // select or release; a released data line must not show the last bit
  task automatic sel(input logic on);
    half();
    spi_cs_n = !on;
    spi_mosi = !spi_mosi;
  endtask : sel

  // one byte each way, msb first, read data taken on the rising edge
  task automatic xfer(input logic [7:0] tx, input logic chk);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      half();
      spi_clk = 1'b1;
      rx_byte = {rx_byte[6:0], spi_miso};
      half();
      spi_clk = 1'b0;
    end
    if (chk) begin
      rx_valid = 1'b1;
      #1;
      rx_valid = 1'b0;
    end
  endtask : xfer
endmodule : sqf_host

// >>> bench/tb_sensor_fifo_frame_formatter.sv
`timescale 1ns/100ps
`include "sqf_cfg.svh"
`define CHK(nm, e, s) begin \
  n_tests++; \
  if ((e) !== (s)) begin \
    err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, s); \
  end \
end
// ==========================================================================
// bench top: host model on the serial port, sensor side driven here
module tb_sensor_fifo_frame_formatter;
  // design inputs
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b1;
  logic         sample_strobe = 1'b0;
  logic [2:0]   sample_avail = 3'h0;
  logic [159:0] sample_data = '0;
  logic [23:0]  sensor_time = 24'h000000;
  logic [3:0]   cfg_change = 4'h0;
  logic         interrupt_pin_one = 1'b0;
  logic         interrupt_pin_two = 1'b0;
  // serial lines and bench state
  logic         spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, rx_valid;
  logic [7:0]   rx_byte, exp_b;
  logic [7:0]   exp_q[$], fr[$];
  logic [31:0]  seed = 32'h00000055;
  int           err_total = 0;
  int           n_tests = 0;

  always #20 clk_sys = ~clk_sys;

  // small queue so overflow comes quickly
  sqf_top #(.AW(5)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .sample_strobe(sample_strobe),
    .sample_avail(sample_avail), .sample_data(sample_data), .sensor_time(sensor_time),
    .cfg_change(cfg_change), .interrupt_pin_one(interrupt_pin_one),
    .interrupt_pin_two(interrupt_pin_two));
  sqf_host u_host (.clk_sys(clk_sys), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .rx_valid(rx_valid), .rx_byte(rx_byte));

  // watcher: every received byte answers the oldest note
  always @(posedge rx_valid) begin
    exp_b = exp_q.pop_front();
    `CHK("read byte", exp_b, rx_byte)
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.sel(1'b1);
    u_host.xfer({1'b0, a}, 1'b0);
    u_host.xfer(d, 1'b0);
    u_host.sel(1'b0);
  endtask : wr

  // burst read; release mid-frame is how a partial read is made
  task automatic rd(input logic [6:0] a, input logic [7:0] e[$]);
    u_host.sel(1'b1);
    u_host.xfer({1'b1, a}, 1'b0);
    foreach (e[i]) begin
      exp_q.push_back(e[i]);
      u_host.xfer(8'h00, 1'b1);
    end
    u_host.sel(1'b0);
  endtask : rd

  // one sample set; expected frame = header (none if zero), then present sensors
  task automatic smp(input logic [2:0] av, input logic [7:0] hdr);
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 5; i++) sample_data[32*i +: 32] = rnd();
    if (hdr != 8'h00) fr.push_back(hdr);
    for (int i = 0; i < 20; i++) begin
      if (av[i < 8 ? 2 : (i < 14 ? 1 : 0)]) begin
        fr.push_back(sample_data[8*i +: 8]);
      end
    end
    sample_avail  = av;
    sample_strobe = 1'b1;
    @(posedge clk_sys);
    #1;
    sample_strobe = 1'b0;
    repeat (30) @(posedge clk_sys);
  endtask : smp

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // watchdog well beyond the expected few hundred microseconds
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  // ========================================================================
  // main sequence
  initial begin
    // real falling edge so the asynchronous reset acts before the first clock
    rst_n <= 1'b0;
    sensor_time = 24'(rnd());
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd(`SQF_ADDR_DOWNS, '{8'h00, 8'h00, 8'h00});
    rd(7'h10, '{8'h00});
    rd(`SQF_ADDR_COUNT_LO, '{8'h00, 8'h00});
    // headerless, accel only: raw bytes then the filler value
    wr(`SQF_ADDR_SETUP_HI, 8'h40);
    smp(3'b001, 8'h00);
    rd(`SQF_ADDR_COUNT_LO, '{8'h06, 8'h00});
    rd(`SQF_ADDR_DATA, {fr, 8'h80, 8'h80});
    // header mode with tag, timestamp, config frame and partial read
    fr.delete();
    wr(`SQF_ADDR_SETUP_HI, 8'hDA);
    @(posedge clk_sys);
    #1;
    cfg_change = 4'h8;
    interrupt_pin_one = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_change = 4'h0;
    repeat (30) @(posedge clk_sys);
    smp(3'b011, 8'h8D);
    rd(`SQF_ADDR_COUNT_LO, '{8'h0F, 8'h00});
    rd(`SQF_ADDR_DATA, '{8'h48, 8'h08, fr[0], fr[1]});
    rd(`SQF_ADDR_DATA, {fr, 8'h44, sensor_time[7:0], sensor_time[15:8],
      sensor_time[23:16], 8'h80});
    // flush keeps the setup
    interrupt_pin_one = 1'b0;
    wr(`SQF_ADDR_CMD, `SQF_CMD_FLUSH);
    rd(`SQF_ADDR_COUNT_LO, '{8'h00, 8'h00});
    rd(`SQF_ADDR_SETUP_HI, '{8'hDA});
    // four frames into 32 bytes: two oldest dropped, skip frame counts them
    smp(3'b001, 8'h84);
    smp(3'b001, 8'h84);
    fr.delete();
    smp(3'b001, 8'h84);
    smp(3'b001, 8'h84);
    rd(`SQF_ADDR_COUNT_LO, '{8'h10, 8'h00});
    rd(`SQF_ADDR_DATA, {8'h40, 8'h02, fr});
    // downsample change flags gyro settings; all three sensors in one frame
    fr.delete();
    wr(`SQF_ADDR_DOWNS, 8'h10);
    wr(`SQF_ADDR_SETUP_HI, 8'hFA);
    smp(3'b111, 8'h9C);
    rd(`SQF_ADDR_DATA, {8'h48, 8'h04, fr});
    final_report();
  end
endmodule : tb_sensor_fifo_frame_formatter

// >>> rtl/sqf_cfg.svh
`ifndef SQF_CFG_SVH
`define SQF_CFG_SVH

// ==========================================================================
// register map (7-bit register addresses on the serial port)
`define SQF_ADDR_COUNT_LO   7'h22
`define SQF_ADDR_COUNT_HI   7'h23
`define SQF_ADDR_DATA       7'h24
`define SQF_ADDR_DOWNS      7'h45
`define SQF_ADDR_SETUP_LO   7'h46
`define SQF_ADDR_SETUP_HI   7'h47
`define SQF_ADDR_CMD        7'h7E
`define SQF_CMD_FLUSH       8'hB0

// ==========================================================================
// reset values
`define SQF_RST_DOWNS       8'h00
`define SQF_RST_SETUP_LO    8'h00
`define SQF_RST_SETUP_HI    8'h00

// ==========================================================================
// field positions in the upper setup byte
`define SQF_SET_TIME        1
`define SQF_SET_TAG2        2
`define SQF_SET_TAG1        3
`define SQF_SET_HDR         4
`define SQF_SET_MAG         5
`define SQF_SET_ACC         6
`define SQF_SET_GYR         7

// ==========================================================================
// header byte layout and codes
`define SQF_KIND_MSB        7
`define SQF_KIND_LSB        6
`define SQF_PARAM_MSB       5
`define SQF_PARAM_LSB       2
`define SQF_KIND_REG        2'h2
`define SQF_KIND_CTL        2'h1
`define SQF_PARAM_SKIP      4'h0
`define SQF_PARAM_TIME      4'h1
`define SQF_PARAM_CFG       4'h2
`define SQF_HDR_INVALID     8'h80
`define SQF_SKIP_SAT        8'hFF

// ==========================================================================
// frame sizes in bytes
`define SQF_MAG_BYTES       5'h08
`define SQF_GYR_BYTES       5'h06
`define SQF_ACC_BYTES       5'h06
`define SQF_CTL_LEN         5'h02
`define SQF_TIME_LEN        5'h04
`define SQF_DATA_BYTES      5'h14
`define SQF_FRAME_MAX       11'h017
`define SQF_SKIP_LEN        16'h0002

`endif

// >>> rtl/sqf_mem.sv
`timescale 1ns/100ps
// ==========================================================================
// queue storage: flip-flop array, one write port, two read ports
module sqf_mem #(
  parameter int AW = 10
) (
  // clock
  input  wire logic          clk_sys,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read ports
  input  wire logic [AW-1:0] rd_addr_a,
  output logic      [7:0]    rd_data_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [7:0]    rd_data_b
);

  logic [7:0] mem [2**AW];

  // storage has no reset: pointers decide what is valid
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule : sqf_mem

// >>> rtl/sqf_pkg.sv
package sqf_pkg;

  // writer sequence, gray coded from idle through the config frame to data
  typedef enum logic [2:0] {
    SQF_WR_IDLE    = 3'h0,
    SQF_WR_DROP    = 3'h1,
    SQF_WR_CFG_HDR = 3'h3,
    SQF_WR_CFG_PAY = 3'h2,
    SQF_WR_HDR     = 3'h6,
    SQF_WR_DATA    = 3'h7
  } sqf_wr_state_t;

  // readout phase within one read operation
  typedef enum logic [2:0] {
    SQF_PH_SKIP_HDR = 3'h0,
    SQF_PH_SKIP_CNT = 3'h1,
    SQF_PH_DATA     = 3'h3,
    SQF_PH_TIME     = 3'h2,
    SQF_PH_END      = 3'h6
  } sqf_phase_t;

endpackage : sqf_pkg

// >>> rtl/sqf_top.sv
`timescale 1ns/100ps
`include "sqf_cfg.svh"
module sqf_top #(
  parameter int AW = 10
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // serial register port
  input  wire logic         spi_clk,
  input  wire logic         spi_cs_n,
  input  wire logic         spi_mosi,
  output logic              spi_miso,
  output logic              spi_miso_oe,
  // sensor side, same clock
  input  wire logic         sample_strobe,
  input  wire logic [2:0]   sample_avail,
  input  wire logic [159:0] sample_data,
  input  wire logic [23:0]  sensor_time,
  input  wire logic [3:0]   cfg_change,
  // external event pins
  input  wire logic         interrupt_pin_one,
  input  wire logic         interrupt_pin_two
);

  localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);

  // ========================================================================
  // helpers
  function automatic logic [4:0] data_len(input logic [2:0] sel);
    return (sel[0] ? `SQF_ACC_BYTES : 5'h00) + (sel[1] ? `SQF_GYR_BYTES : 5'h00)
         + (sel[2] ? `SQF_MAG_BYTES : 5'h00);
  endfunction : data_len

  function automatic logic [4:0] frame_len(input logic [7:0] hdr);
    if (hdr[`SQF_KIND_MSB:`SQF_KIND_LSB] == `SQF_KIND_CTL) begin
      return `SQF_CTL_LEN;
    end
    return 5'h01 + data_len(hdr[`SQF_PARAM_LSB+2:`SQF_PARAM_LSB]);
  endfunction : frame_len

  function automatic logic byte_used(input logic [4:0] idx, input logic [2:0] sel);
    // register order: magnetic 0..7, gyro 8..13, accel 14..19
    if (idx < `SQF_MAG_BYTES) begin
      return sel[2];
    end else if (idx < `SQF_MAG_BYTES + `SQF_GYR_BYTES) begin
      return sel[1];
    end
    return sel[0];
  endfunction : byte_used

  // ========================================================================
  // pin synchronisers
  logic [2:0] sclk_s, cs_s, interrupt_pin_one_s, interrupt_pin_two_s;
  logic [1:0] mosi_s;

  // two flops before use, third flop only for edge finding
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      interrupt_pin_one_s <= 3'h0;
      interrupt_pin_two_s <= 3'h0;
      mosi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_clk};
      cs_s   <= {cs_s[1:0], spi_cs_n};
      interrupt_pin_one_s <= {interrupt_pin_one_s[1:0], interrupt_pin_one};
      interrupt_pin_two_s <= {interrupt_pin_two_s[1:0], interrupt_pin_two};
      mosi_s <= {mosi_s[0], spi_mosi};
    end
  end

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_act    = ~cs_s[1];
  wire cs_start  = ~cs_s[1] & cs_s[2];
  wire cs_end    = cs_s[1] & ~cs_s[2];

  // ========================================================================
  // serial slave: address byte (bit7 = read), then data bytes
  logic [2:0] bit_cnt;
  logic [6:0] rx_sr;
  logic [6:0] addr;
  logic [7:0] tx_sr;
  logic       first, is_read;
  logic [7:0] rd_mux;

  wire [7:0] rx_byte   = {rx_sr, mosi_s[1]};
  wire       byte_done = cs_act & sclk_rise & (bit_cnt == 3'h7);
  wire [6:0] addr_next = (addr == `SQF_ADDR_DATA) ? addr : addr + 7'h01;
  wire       fetch_en  = byte_done & (first ? rx_byte[7] : is_read);
  wire [6:0] fetch_addr = first ? rx_byte[6:0] : addr_next;
  wire       reg_wr    = byte_done & ~first & ~is_read;
  wire       rd_fire   = fetch_en & (fetch_addr == `SQF_ADDR_DATA);

  // byte shifting; miso changes on falling edges only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt     <= 3'h0;
      rx_sr       <= 7'h00;
      addr        <= 7'h00;
      tx_sr       <= 8'h00;
      first       <= 1'b1;
      is_read     <= 1'b0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (!cs_act) begin
      bit_cnt     <= 3'h0;
      first       <= 1'b1;
      is_read     <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      if (sclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_sr   <= rx_byte[6:0];
      end
      if (byte_done) begin
        first <= 1'b0;
        if (first) begin
          is_read <= rx_byte[7];
          addr    <= rx_byte[6:0];
        end else if (is_read) begin
          addr <= addr_next;
        end else begin
          addr <= addr + 7'h01;
        end
      end
      if (fetch_en) begin
        tx_sr <= rd_mux;
      end else if (sclk_fall && is_read && !first) begin
        spi_miso    <= tx_sr[7];
        tx_sr       <= {tx_sr[6:0], 1'b0};
        spi_miso_oe <= 1'b1;
      end
    end
  end

  // ========================================================================
  // registers
  logic [7:0] downs, setup_lo, setup_hi;
  wire        hdr_mode = setup_hi[`SQF_SET_HDR];
  wire        time_en  = setup_hi[`SQF_SET_TIME];
  wire [2:0]  sel_en   = {setup_hi[`SQF_SET_MAG], setup_hi[`SQF_SET_GYR],
                          setup_hi[`SQF_SET_ACC]};
  wire [2:0]  new_sel  = {rx_byte[`SQF_SET_MAG], rx_byte[`SQF_SET_GYR],
                          rx_byte[`SQF_SET_ACC]};
  wire        wr_setup = reg_wr & (addr == `SQF_ADDR_SETUP_HI);
  wire        wr_downs = reg_wr & (addr == `SQF_ADDR_DOWNS);
  wire        cmd_flush = reg_wr & (addr == `SQF_ADDR_CMD) & (rx_byte == `SQF_CMD_FLUSH);
  wire        auto_flush = wr_setup & ((rx_byte[`SQF_SET_HDR] != hdr_mode)
                         | (!hdr_mode & (new_sel != sel_en)));
  wire        flush = cmd_flush | auto_flush;
  // downsample changes count as settings changes of gyro (high nibble) and accel
  wire [3:0]  downs_chg = wr_downs ? {1'b0, rx_byte[7:4] != downs[7:4],
                                      1'b0, rx_byte[3:0] != downs[3:0]} : 4'h0;

  // register writes; the setup byte steers the whole queue
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      downs    <= `SQF_RST_DOWNS;
      setup_lo <= `SQF_RST_SETUP_LO;
      setup_hi <= `SQF_RST_SETUP_HI;
    end else if (reg_wr) begin
      if (addr == `SQF_ADDR_DOWNS) begin
        downs <= rx_byte;
      end else if (addr == `SQF_ADDR_SETUP_LO) begin
        setup_lo <= rx_byte;
      end else if (addr == `SQF_ADDR_SETUP_HI) begin
        setup_hi <= rx_byte;
      end
    end
  end

  // ========================================================================
  // queue pointers and storage
  logic [AW:0] wr_ptr, rd_ptr, peek;
  logic [7:0]  mem_a, mem_b;
  logic        wr_en;
  logic [7:0]  wr_byte;
  logic        skip_pend;
  logic [7:0]  skip_cnt;

  wire [AW:0] count    = wr_ptr - rd_ptr;
  wire [AW:0] free     = DEPTH - count;
  wire [15:0] cnt_reg  = 16'(count) + ((hdr_mode & skip_pend) ? `SQF_SKIP_LEN : 16'h0000);

  sqf_mem #(.AW(AW)) u_mem (
    .clk_sys   (clk_sys),
    .wr_en     (wr_en),
    .wr_addr   (wr_ptr[AW-1:0]),
    .wr_data   (wr_byte),
    .rd_addr_a (peek[AW-1:0]),
    .rd_data_a (mem_a),
    .rd_addr_b (rd_ptr[AW-1:0]),
    .rd_data_b (mem_b)
  );

  // ========================================================================
  // writer: in header mode optional config frame and header, then present data bytes
  sqf_pkg::sqf_wr_state_t ws;
  logic [159:0] cap_data;
  logic [2:0]   cap_sel;
  logic [4:0]   widx;
  logic [3:0]   cfg_pend;
  logic [1:0]   tag_pend;

  wire [2:0] cap_now  = sample_avail & sel_en;
  wire       cap_ok   = hdr_mode ? (cap_now != 3'h0)
                                 : ((cap_now == sel_en) & (sel_en != 3'h0));
  wire       need_drop = (ws == sqf_pkg::SQF_WR_DROP) & (free < `SQF_FRAME_MAX)
                       & (count != '0);
  wire [4:0] drop_len = hdr_mode ? frame_len(mem_b) : data_len(sel_en);
  wire       cfg_clr  = ws == sqf_pkg::SQF_WR_CFG_PAY;
  wire       tag_clr  = ws == sqf_pkg::SQF_WR_HDR;
  wire [1:0] tag_edge = {interrupt_pin_two_s[1] & ~interrupt_pin_two_s[2] & setup_hi[`SQF_SET_TAG2],
                         interrupt_pin_one_s[1] & ~interrupt_pin_one_s[2] & setup_hi[`SQF_SET_TAG1]};

  // byte to store this cycle
  always_comb begin
    wr_en   = 1'b0;
    wr_byte = 8'h00;
    case (ws)
      sqf_pkg::SQF_WR_CFG_HDR: begin
        wr_en   = 1'b1;
        wr_byte = {`SQF_KIND_CTL, `SQF_PARAM_CFG, 2'h0};
      end
      sqf_pkg::SQF_WR_CFG_PAY: begin
        wr_en   = 1'b1;
        wr_byte = {4'h0, cfg_pend};
      end
      sqf_pkg::SQF_WR_HDR: begin
        wr_en   = 1'b1;
        wr_byte = {`SQF_KIND_REG, 1'b0, cap_sel, tag_pend};
      end
      sqf_pkg::SQF_WR_DATA: begin
        wr_en   = byte_used(widx, cap_sel);
        wr_byte = cap_data[{widx, 3'h0} +: 8];
      end
      default: begin
        wr_en   = 1'b0;
      end
    endcase
  end

  // writer sequence; a strobe while busy is not taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ws       <= sqf_pkg::SQF_WR_IDLE;
      wr_ptr   <= '0;
      cap_data <= '0;
      cap_sel  <= 3'h0;
      widx     <= 5'h00;
    end else if (flush) begin
      ws     <= sqf_pkg::SQF_WR_IDLE;
      wr_ptr <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      case (ws)
        sqf_pkg::SQF_WR_IDLE: begin
          if (sample_strobe && cap_ok) begin
            cap_data <= sample_data;
            cap_sel  <= cap_now;
            ws       <= sqf_pkg::SQF_WR_DROP;
          end
        end
        sqf_pkg::SQF_WR_DROP: begin
          widx <= 5'h00;
          if (!need_drop) begin
            ws <= !hdr_mode ? sqf_pkg::SQF_WR_DATA :
                  (cfg_pend != 4'h0) ? sqf_pkg::SQF_WR_CFG_HDR : sqf_pkg::SQF_WR_HDR;
          end
        end
        sqf_pkg::SQF_WR_CFG_HDR: ws <= sqf_pkg::SQF_WR_CFG_PAY;
        sqf_pkg::SQF_WR_CFG_PAY: ws <= sqf_pkg::SQF_WR_HDR;
        sqf_pkg::SQF_WR_HDR:     ws <= sqf_pkg::SQF_WR_DATA;
        default: begin
          widx <= widx + 5'h01;
          if (widx == `SQF_DATA_BYTES - 5'h01) begin
            ws <= sqf_pkg::SQF_WR_IDLE;
          end
        end
      endcase
    end
  end

  // pending config bits and tags; a new event wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_pend <= 4'h0;
      tag_pend <= 2'h0;
    end else begin
      cfg_pend <= (cfg_pend & ~(cfg_clr ? cfg_pend : 4'h0)) | cfg_change | downs_chg;
      if (tag_edge != 2'h0) begin
        tag_pend <= {interrupt_pin_two_s[1], interrupt_pin_one_s[1]};
      end else if (tag_clr) begin
        tag_pend <= 2'h0;
      end
    end
  end

  // ========================================================================
  // reader: skip frame, stored frames, timestamp frame, then 0x80
  sqf_pkg::sqf_phase_t phase;
  logic [4:0]  frame_left;
  logic [1:0]  ts_idx;
  logic [23:0] ts_cap;
  logic        commit_pend, skip_ack;
  logic [AW:0] commit_ptr;

  wire        q_empty  = (peek == wr_ptr) & (frame_left == 5'h00);
  wire [4:0]  cur_len  = hdr_mode ? frame_len(mem_a) : data_len(sel_en);
  wire [4:0]  left_new = ((frame_left == 5'h00) ? cur_len : frame_left) - 5'h01;
  // count byte clears the skip only once the host has clocked it out
  wire        skip_clr = rd_fire & skip_ack;
  wire        to_time  = hdr_mode & time_en;
  logic [7:0] q_byte;

  // byte returned for a read of the data register
  always_comb begin
    case (phase)
      sqf_pkg::SQF_PH_SKIP_HDR: q_byte = {`SQF_KIND_CTL, `SQF_PARAM_SKIP, 2'h0};
      sqf_pkg::SQF_PH_SKIP_CNT: q_byte = skip_cnt;
      sqf_pkg::SQF_PH_DATA: begin
        if (!q_empty) begin
          q_byte = mem_a;
        end else if (to_time) begin
          q_byte = {`SQF_KIND_CTL, `SQF_PARAM_TIME, 2'h0};
        end else begin
          q_byte = `SQF_HDR_INVALID;
        end
      end
      sqf_pkg::SQF_PH_TIME: q_byte = ts_cap[{ts_idx, 3'h0} +: 8];
      default:              q_byte = `SQF_HDR_INVALID;
    endcase
  end

  // read pointer, peek pointer and phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr     <= '0;
      peek       <= '0;
      frame_left <= 5'h00;
      phase      <= sqf_pkg::SQF_PH_DATA;
      ts_idx     <= 2'h0;
      ts_cap     <= 24'h000000;
      commit_pend <= 1'b0;
      commit_ptr  <= '0;
      skip_ack    <= 1'b0;
    end else if (flush) begin
      rd_ptr     <= '0;
      peek       <= '0;
      frame_left <= 5'h00;
      phase      <= sqf_pkg::SQF_PH_DATA;
      commit_pend <= 1'b0;
      skip_ack    <= 1'b0;
    end else if (need_drop) begin
      // host mid-frame on the dropped frame restarts at the new oldest
      rd_ptr     <= rd_ptr + (AW+1)'(drop_len);
      peek       <= rd_ptr + (AW+1)'(drop_len);
      frame_left <= 5'h00;
      commit_pend <= 1'b0;
    end else if (cs_start || cs_end) begin
      peek       <= rd_ptr;
      frame_left <= 5'h00;
      ts_idx     <= 2'h0;
      commit_pend <= 1'b0;
      skip_ack    <= 1'b0;
      phase      <= (hdr_mode && skip_pend) ? sqf_pkg::SQF_PH_SKIP_HDR
                                            : sqf_pkg::SQF_PH_DATA;
    end else if (rd_fire) begin
      // each fetch is a prefetch: a finished frame commits once delivered
      if (commit_pend) begin
        rd_ptr <= commit_ptr;
        ts_cap <= sensor_time;
      end
      commit_pend <= 1'b0;
      skip_ack    <= phase == sqf_pkg::SQF_PH_SKIP_CNT;
      case (phase)
        sqf_pkg::SQF_PH_SKIP_HDR: phase <= sqf_pkg::SQF_PH_SKIP_CNT;
        sqf_pkg::SQF_PH_SKIP_CNT: phase <= sqf_pkg::SQF_PH_DATA;
        sqf_pkg::SQF_PH_DATA: begin
          if (q_empty) begin
            if (to_time) begin
              phase <= sqf_pkg::SQF_PH_TIME;
            end
          end else begin
            peek       <= peek + 1'b1;
            frame_left <= left_new;
            if (left_new == 5'h00) begin
              commit_pend <= 1'b1;
              commit_ptr  <= peek + 1'b1;
            end
          end
        end
        sqf_pkg::SQF_PH_TIME: begin
          ts_idx <= ts_idx + 2'h1;
          if (ts_idx == 2'h2) begin
            phase <= sqf_pkg::SQF_PH_END;
          end
        end
        default: phase <= sqf_pkg::SQF_PH_END;
      endcase
    end
  end

  // skipped-frame count; a drop in the clearing cycle still counts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      skip_pend <= 1'b0;
      skip_cnt  <= 8'h00;
    end else if (flush) begin
      skip_pend <= 1'b0;
      skip_cnt  <= 8'h00;
    end else if (need_drop && hdr_mode) begin
      skip_pend <= 1'b1;
      skip_cnt  <= skip_clr ? 8'h01 :
                   (skip_cnt == `SQF_SKIP_SAT) ? skip_cnt : skip_cnt + 8'h01;
    end else if (skip_clr) begin
      skip_pend <= 1'b0;
      skip_cnt  <= 8'h00;
    end
  end

  // ========================================================================
  // register read decode
  assign rd_mux = (fetch_addr == `SQF_ADDR_COUNT_LO) ? cnt_reg[7:0]  :
                  (fetch_addr == `SQF_ADDR_COUNT_HI) ? cnt_reg[15:8] :
                  (fetch_addr == `SQF_ADDR_DATA)     ? q_byte        :
                  (fetch_addr == `SQF_ADDR_DOWNS)    ? downs         :
                  (fetch_addr == `SQF_ADDR_SETUP_LO) ? setup_lo      :
                  (fetch_addr == `SQF_ADDR_SETUP_HI) ? setup_hi      : 8'h00;

endmodule : sqf_top
